// file: inc/scc_pkg.sv
// Package of constants and types for the coprocessor register bank.
// Operation
// - Auxiliary identity register reads as all zeros.
// - Auxiliary identity read uses opcode1 1, c0, c0, opcode2 7.
// - All three registers are accessible only from privileged modes.
// - Auxiliary identity is one copy common to both security states.
// - Cache size select is banked; the access state picks the copy.
// - Select bit 0: one picks instruction cache, zero picks data cache.
// - Cache level bits 3 to 1 read zero and ignore writes.
// - Cache size select uses opcode1 2, c0, c0, opcode2 0.
// - Size identity top nibble is 0010 for instruction, 0111 for data.
// - User mode access to system control raises undefined instruction.
// - Secure privileged write with write-disable high is undefined.
// - Writes to read-only system control bits leave them unchanged.
// - System control keeps banked bits per security state.
// - Bit 30 picks the instruction state used on exception entry.
// - Bit 30 is loaded from the exception-state init pin at reset.
// - Bit 29 enables the access flag; resets to zero.
// - Bit 28 enables memory attribute remap; resets to zero.
// - Exception entry copies bit 25 into the status endian bit.
// - Table walks use the byte order given by bit 25.
// - System control uses opcode1 0, c1, c0, opcode2 0.
package scc_pkg;
	// ****************************************************************
	// Instruction field encodings
	// ****************************************************************
	localparam logic [3:0] SCC_CP_NUM       = 4'hF;
	localparam logic [2:0] SCC_OP1_AUXID    = 3'h1;
	localparam logic [2:0] SCC_OP2_AUXID    = 3'h7;
	localparam logic [2:0] SCC_OP1_CSSEL    = 3'h2;
	localparam logic [2:0] SCC_OP2_CSSEL    = 3'h0;
	localparam logic [2:0] SCC_OP1_SYSCTL   = 3'h0;
	localparam logic [2:0] SCC_OP2_SYSCTL   = 3'h0;
	localparam logic [3:0] SCC_CRN_C0       = 4'h0;
	localparam logic [3:0] SCC_CRN_C1       = 4'h1;
	localparam logic [3:0] SCC_CRM_C0       = 4'h0;
	localparam logic [4:0] SCC_MODE_USER    = 5'h10;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         SCC_SEL_IND_BIT  = 0;
	localparam int         SCC_SC_TE_BIT    = 30;
	localparam int         SCC_SC_AFE_BIT   = 29;
	localparam int         SCC_SC_TRE_BIT   = 28;
	localparam int         SCC_SC_EXCEPTION_ENDIAN    = 25;
	localparam logic [3:0] SCC_CSID_TOP_I   = 4'h2;
	localparam logic [3:0] SCC_CSID_TOP_D   = 4'h7;
	localparam logic       SCC_AFE_RST      = 1'h0;
	localparam logic       SCC_TRE_RST      = 1'h0;
	localparam logic       SCC_EE_RST       = 1'h0;
	localparam logic       SCC_IND_RST      = 1'h0;

	// Register selected by a decoded instruction.
	typedef enum logic [3:0] {
		SCC_REG_NONE  = 4'h1,
		SCC_REG_AUXID = 4'h2,
		SCC_REG_CSSEL = 4'h4,
		SCC_REG_SCTL  = 4'h8
	} scc_reg_t;
endpackage : scc_pkg

// file: verilog/scc_regs.sv
// Coprocessor register bank: auxiliary identity, cache select, control.
`timescale 1ns/1ps
`default_nettype none
module scc_regs (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_exception_state_init_pin,
	input  wire logic             i_secure_coproc_write_disable,
	input  wire logic             i_req,
	input  wire logic             i_wr,
	input  wire logic [3:0]       i_cp_num,
	input  wire logic [2:0]       i_op1,
	input  wire logic [3:0]       i_crn,
	input  wire logic [3:0]       i_crm,
	input  wire logic [2:0]       i_op2,
	input  wire logic [4:0]       i_mode,
	input  wire logic             i_secure,
	input  wire logic [31:0]      i_wdata,
	input  wire logic             i_exc_entry,
	output logic                  o_ack,
	output logic                  o_undef,
	output logic [31:0]           o_rdata,
	output logic [3:0]            o_csid_top,
	output logic                  o_exception_state_select,
	output logic                  o_access_flag_enable,
	output logic                  o_attr_remap_enable,
	output logic                  o_exception_endian,
	output logic                  o_walk_big_endian,
	output logic                  o_status_endian_bit,
	output logic                  o_status_endian_load
);
	import scc_pkg::*;

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Decodes the instruction fields to one register.
	function automatic scc_reg_t scc_decode(input logic [3:0] cp,
		input logic [2:0] o1, input logic [3:0] n, input logic [3:0] m,
		input logic [2:0] o2);
		scc_reg_t r;
		r = SCC_REG_NONE;
		if (cp == SCC_CP_NUM && m == SCC_CRM_C0) begin
			if (n == SCC_CRN_C0 && o1 == SCC_OP1_AUXID &&
				o2 == SCC_OP2_AUXID)
				r = SCC_REG_AUXID;
			else if (n == SCC_CRN_C0 && o1 == SCC_OP1_CSSEL &&
				o2 == SCC_OP2_CSSEL)
				r = SCC_REG_CSSEL;
			else if (n == SCC_CRN_C1 && o1 == SCC_OP1_SYSCTL &&
				o2 == SCC_OP2_SYSCTL)
				r = SCC_REG_SCTL;
		end
		return r;
	endfunction : scc_decode

	scc_reg_t sel;
	logic     priv;
	logic     illegal;
	logic     do_wr;

	// Access checks: privilege, secure write disable, read-only register.
	always_comb begin
		sel     = scc_decode(i_cp_num, i_op1, i_crn, i_crm, i_op2);
		priv    = (i_mode != SCC_MODE_USER);
		illegal = 1'b0;
		case (sel)
			SCC_REG_AUXID: illegal = !priv || i_wr;
			SCC_REG_CSSEL: illegal = !priv;
			SCC_REG_SCTL:  illegal = !priv ||
				(i_wr && i_secure && i_secure_coproc_write_disable);
			SCC_REG_NONE:  illegal = 1'b1;
			default:       illegal = 1'b1;
		endcase
		do_wr = i_req && i_wr && !illegal;
	end

	// ****************************************************************
	// Storage
	// ****************************************************************
	// Banked copies, index 1 is secure, index 0 non-secure.
	logic [1:0] ind_r;
	logic [1:0] te_r;
	logic [1:0] afe_r;
	logic [1:0] tre_r;
	logic [1:0] ee_r;
	logic [1:0] te_init_r;
	logic       bank;

	assign bank = i_secure;

	// Cache select copies; only the selection bit is stored.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ind_r <= {2{SCC_IND_RST}};
		end else if (do_wr && sel == SCC_REG_CSSEL) begin
			ind_r[bank] <= i_wdata[SCC_SEL_IND_BIT];
		end
	end

	// Exception-state bit reset loads from the pin level.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			te_init_r <= 2'h3; // Marks that the pin must be captured.
		end else begin
			te_init_r <= 2'h0;
		end
	end

	// Control bits 29, 28, 25 per bank; bit 30 is stored in the next block.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			afe_r <= {2{SCC_AFE_RST}};
			tre_r <= {2{SCC_TRE_RST}};
			ee_r  <= {2{SCC_EE_RST}};
		end else if (do_wr && sel == SCC_REG_SCTL) begin
			afe_r[bank] <= i_wdata[SCC_SC_AFE_BIT];
			tre_r[bank] <= i_wdata[SCC_SC_TRE_BIT];
			ee_r[bank]  <= i_wdata[SCC_SC_EXCEPTION_ENDIAN];
		end
	end

	// Exception-state bit: pin level caught at the first edge after reset.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			te_r <= 2'h0;
		end else if (te_init_r[0]) begin
			te_r <= {2{i_exception_state_init_pin}};
		end else if (do_wr && sel == SCC_REG_SCTL) begin
			te_r[bank] <= i_wdata[SCC_SC_TE_BIT];
		end
	end

	// ****************************************************************
	// Read path and response
	// ****************************************************************
	logic [31:0] rd_nxt;

	// Read value; reserved and read-only bits assemble as zero.
	always_comb begin
		rd_nxt = 32'h0;
		case (sel)
			SCC_REG_AUXID: rd_nxt = 32'h0;
			SCC_REG_CSSEL: rd_nxt[SCC_SEL_IND_BIT] = ind_r[bank];
			SCC_REG_SCTL: begin
				rd_nxt[SCC_SC_TE_BIT]  = te_r[bank];
				rd_nxt[SCC_SC_AFE_BIT] = afe_r[bank];
				rd_nxt[SCC_SC_TRE_BIT] = tre_r[bank];
				rd_nxt[SCC_SC_EXCEPTION_ENDIAN]  = ee_r[bank];
			end
			SCC_REG_NONE: rd_nxt = 32'h0;
			default:      rd_nxt = 32'h0;
		endcase
	end

	// One-cycle answer after each request.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_ack   <= 1'b0;
			o_undef <= 1'b0;
			o_rdata <= 32'h0;
		end else begin
			o_ack   <= i_req;
			o_undef <= i_req && illegal;
			o_rdata <= (i_req && !i_wr && !illegal) ? rd_nxt : 32'h0;
		end
	end

	// Size identity top nibble follows the current-state selection.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_csid_top <= SCC_CSID_TOP_D;
		end else begin
			o_csid_top <= ind_r[bank] ? SCC_CSID_TOP_I
				: SCC_CSID_TOP_D;
		end
	end

	// Control bit outputs for the current security state.
	always_comb begin
		o_exception_state_select = te_r[bank];
		o_access_flag_enable     = afe_r[bank];
		o_attr_remap_enable      = tre_r[bank];
		o_exception_endian       = ee_r[bank];
		o_walk_big_endian        = ee_r[bank];
	end

	// Endian bit copied into the status register on exception entry.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_status_endian_bit  <= 1'b0;
			o_status_endian_load <= 1'b0;
		end else begin
			o_status_endian_bit  <= i_exc_entry ? ee_r[bank]
				: o_status_endian_bit;
			o_status_endian_load <= i_exc_entry;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_user_sctl;
		i_req && i_mode == SCC_MODE_USER && sel == SCC_REG_SCTL;
	endsequence

	AST_USER_UNDEF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_user_sctl |=> o_undef && o_ack)
		else $error("user access to control not undefined");
	AST_SDIS_UNDEF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_req && i_wr && priv && i_secure && i_secure_coproc_write_disable
		&& sel == SCC_REG_SCTL |=> o_undef)
		else $error("secure write with disable not undefined");
	AST_AUX_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_req && !i_wr && priv && sel == SCC_REG_AUXID
		|=> o_rdata == 32'h0 && !o_undef)
		else $error("auxiliary identity not zero");
	AST_PRIV_CSSEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_req && !priv && sel == SCC_REG_CSSEL |=> o_undef)
		else $error("user access to cache select allowed");
	AST_CSSEL_RAZ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_req && !i_wr && priv && sel == SCC_REG_CSSEL
		|=> o_rdata[31:1] == 31'h0)
		else $error("cache select upper bits not zero");
	AST_CSID_TOP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_req && i_wr && priv && sel == SCC_REG_CSSEL &&
		i_wdata[0] ##1 $stable(i_secure)
		|=> o_csid_top == SCC_CSID_TOP_I)
		else $error("size identity not instruction cache");
	AST_AFE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		do_wr && sel == SCC_REG_SCTL
		|=> afe_r[$past(bank)] == $past(i_wdata[SCC_SC_AFE_BIT]))
		else $error("access flag enable not updated");
	AST_TE_INIT: assert property (@(posedge i_clk)
		!$past(i_rst_n) && i_rst_n
		|=> te_r == {2{$past(i_exception_state_init_pin)}})
		else $error("exception state not loaded from pin");
	AST_EE_COPY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_exc_entry |=> o_status_endian_load &&
		o_status_endian_bit == $past(ee_r[bank]))
		else $error("endian bit not copied on exception");
endmodule : scc_regs
`default_nettype wire

// file: dv/scc_core_model.sv
// Core pipeline model that issues coprocessor instructions to the bank.
`timescale 1ns/1ps
`default_nettype none
module scc_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic        i_undef,
	input  wire logic [31:0] i_rdata,
	output logic             o_req,
	output logic             o_wr,
	output logic [3:0]       o_cp_num,
	output logic [2:0]       o_op1,
	output logic [3:0]       o_crn,
	output logic [3:0]       o_crm,
	output logic [2:0]       o_op2,
	output logic [4:0]       o_mode,
	output logic             o_secure,
	output logic [31:0]      o_wdata
);
	// Software, not this model, flushes translations after bit 29 changes.
	// Idle values; mode and state stay as the core's level state.
	initial begin
		o_req = 1'h0;
		o_wr = 1'h0;
		o_cp_num = 4'hF;
		o_op1 = 3'h0;
		o_crn = 4'h0;
		o_crm = 4'h0;
		o_op2 = 3'h0;
		o_mode = 5'h13;
		o_secure = 1'h1;
		o_wdata = 32'h0;
	end

	// One instruction: driven after a falling edge, answer taken a cycle on.
	task automatic issue(input logic w, input logic [2:0] a,
		input logic [3:0] n, input logic [2:0] b, input logic [4:0] m,
		input logic s, input logic [31:0] d, output logic ak,
		output logic un, output logic [31:0] rd);
		@(negedge i_clk);
		{o_req, o_wr, o_op1, o_crn, o_op2} = {1'h1, w, a, n, b};
		{o_mode, o_secure, o_wdata} = {m, s, d};
		@(negedge i_clk);
		o_req = 1'h0;
		// Released write data no longer shows the last value.
		o_wdata = ~d;
		{ak, un, rd} = {i_ack, i_undef, i_rdata};
	endtask : issue
endmodule : scc_core_model
`default_nettype wire

// file: dv/scc_regs_tb.sv
// Self-checking testbench for the coprocessor register bank.
`timescale 1ns/1ps
`default_nettype none
module scc_regs_tb;
	import scc_pkg::*;
	localparam logic [4:0] PRV = 5'h13;
	logic clk, rst_n, tein, wdis, exc, req, wr, sec, ack, und, ese, afe;
	logic attr_remap_enable, ee, wbe, seb, sel;
	logic [3:0] cp, crn, crm, top;
	logic [2:0] op1, op2;
	logic [4:0] md;
	logic [31:0] wd, rd;
	logic ak, un;
	logic [31:0] rv;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;

	scc_regs i_scc_regs (.i_clk(clk), .i_rst_n(rst_n),
		.i_exception_state_init_pin(tein),
		.i_secure_coproc_write_disable(wdis), .i_req(req), .i_wr(wr),
		.i_cp_num(cp), .i_op1(op1), .i_crn(crn), .i_crm(crm), .i_op2(op2),
		.i_mode(md), .i_secure(sec), .i_wdata(wd), .i_exc_entry(exc),
		.o_ack(ack), .o_undef(und), .o_rdata(rd), .o_csid_top(top),
		.o_exception_state_select(ese), .o_access_flag_enable(afe),
		.o_attr_remap_enable(attr_remap_enable), .o_exception_endian(ee),
		.o_walk_big_endian(wbe), .o_status_endian_bit(seb),
		.o_status_endian_load(sel));
	scc_core_model i_scc_core_model (.i_clk(clk), .i_ack(ack),
		.i_undef(und), .i_rdata(rd), .o_req(req), .o_wr(wr),
		.o_cp_num(cp), .o_op1(op1), .o_crn(crn), .o_crm(crm),
		.o_op2(op2), .o_mode(md), .o_secure(sec), .o_wdata(wd));

	// Clock at 25 ns and a cycle ceiling against hangs.
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Issue one instruction; every request must be answered.
	task automatic rq(input logic w, input logic [2:0] a, input logic [3:0] n,
		input logic [2:0] b, input logic [4:0] m, input logic s,
		input logic [31:0] d);
		i_scc_core_model.issue(w, a, n, b, m, s, d, ak, un, rv);
		chk("ack", 1'h1, ak);
	endtask : rq

	task automatic t_aux();
		for (int s = 0; s < 2; s++) begin
			rq(0, 3'h1, 4'h0, 3'h7, PRV, s[0], 0);
			chk("aux undef", 0, un);
			chk("aux data", 0, rv);
		end
		rq(0, 3'h1, 4'h0, 3'h7, SCC_MODE_USER, 1, 0);
		chk("aux user", 1, un);
		rq(1, 3'h1, 4'h0, 3'h7, PRV, 1, 32'hFFFFFFFF);
		chk("aux write", 1, un);
		rq(0, 3'h1, 4'h0, 3'h6, PRV, 1, 0);
		chk("unmapped", 1, un);
	endtask : t_aux

	task automatic t_csel();
		rq(1, 3'h2, 4'h0, 3'h0, PRV, 1, 32'hFFFFFFFF);
		rq(0, 3'h2, 4'h0, 3'h0, PRV, 1, 0);
		chk("sel sec", 32'h1, rv);
		chk("csid i", 4'h2, top);
		rq(0, 3'h2, 4'h0, 3'h0, PRV, 0, 0);
		chk("sel ns", 32'h0, rv);
		chk("csid d", 4'h7, top);
		rq(0, 3'h2, 4'h0, 3'h0, SCC_MODE_USER, 0, 0);
		chk("sel user", 1, un);
	endtask : t_csel

	task automatic t_sctl();
		for (int s = 0; s < 2; s++) begin
			rq(0, 3'h0, 4'h1, 3'h0, PRV, s[0], 0);
			chk("sc reset", 32'h40000000, rv);
		end
		rq(1, 3'h0, 4'h1, 3'h0, PRV, 0, 32'hFFFFFFFF);
		rq(0, 3'h0, 4'h1, 3'h0, PRV, 0, 0);
		chk("sc ns", 32'h72000000, rv);
		chk("afe", 1, afe);
		chk("tre", 1, attr_remap_enable);
		chk("walk", 1, wbe);
		chk("ee", 1, ee);
		rq(0, 3'h0, 4'h1, 3'h0, SCC_MODE_USER, 0, 0);
		chk("sc user rd", 1, un);
		rq(1, 3'h0, 4'h1, 3'h0, SCC_MODE_USER, 1, 0);
		chk("sc user wr", 1, un);
		wdis = 1'h1;
		rq(1, 3'h0, 4'h1, 3'h0, PRV, 1, 0);
		chk("sc locked", 1, un);
		rq(0, 3'h0, 4'h1, 3'h0, PRV, 1, 0);
		chk("sc sec", 32'h40000000, rv);
		wdis = 1'h0;
	endtask : t_sctl

	// Exception entry copies the endian bit of the shown bank.
	task automatic t_exc();
		rq(0, 3'h0, 4'h1, 3'h0, PRV, 0, 0);
		@(negedge clk);
		exc = 1'h1;
		@(negedge clk);
		exc = 1'h0;
		chk("end load", 1, sel);
		chk("end bit", 1, seb);
		rq(0, 3'h0, 4'h1, 3'h0, PRV, 1, 0);
		@(negedge clk);
		exc = 1'h1;
		@(negedge clk);
		exc = 1'h0;
		chk("end load s", 1, sel);
		chk("end bit s", 0, seb);
	endtask : t_exc

	task automatic end_sim();
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// Reset for two cycles, then run every scenario.
	initial begin
		{rst_n, tein, wdis, exc} = 4'h4;
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		repeat (2) @(negedge clk);
		chk("te", 1, ese);
		t_aux();
		t_csel();
		t_sctl();
		t_exc();
		end_sim();
	end
endmodule : scc_regs_tb
`default_nettype wire
